// ===== rtl/dmap_addr_align.sv
`timescale 1ns/10ps
`default_nettype none
module dmap_addr_align (
  dmap_align_if.calc p
);
  import dmap_pkg::*;

  // low bits pass straight through unless alignment forcing is enabled
  assign p.bus_addr = p.fix_en ?
                      {p.addr[31:2], p.addr[1:0] & ~dmap_low_mask(p.size)} :
                      p.addr;

endmodule
`default_nettype wire

// ===== rtl/dmap_align_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dmap_align_if;
  logic [31:0] addr;
  logic [2:0]  size;
  logic        fix_en;
  logic [31:0] bus_addr;

  modport calc (
    input  addr,
    input  size,
    input  fix_en,
    output bus_addr
  );

  modport user (
    output addr,
    output size,
    output fix_en,
    input  bus_addr
  );
endinterface
`default_nettype wire

// ===== rtl/dmap_pkg.sv
`default_nettype none
package dmap_pkg;

  // debugger-side register select codes
  localparam int          DMAP_SEL_W      = 2;
  localparam logic [1:0]  DMAP_SEL_CTRL   = 2'h0;
  localparam logic [1:0]  DMAP_SEL_ADDR   = 2'h1;
  localparam logic [1:0]  DMAP_SEL_DATA   = 2'h3;

  // access control register layout
  localparam int          DMAP_SIZE_LSB   = 0;
  localparam int          DMAP_SIZE_W     = 3;
  localparam int          DMAP_INCR_BIT   = 4;
  localparam int          DMAP_ERR_BIT    = 6;
  localparam int          DMAP_BUSY_BIT   = 7;

  // transfer size encodings, as driven on hsize
  localparam logic [2:0]  DMAP_SIZE_BYTE  = 3'h0;
  localparam logic [2:0]  DMAP_SIZE_HALF  = 3'h1;
  localparam logic [2:0]  DMAP_SIZE_WORD  = 3'h2;

  // reset values
  localparam logic [2:0]  DMAP_SIZE_RST   = DMAP_SIZE_WORD;
  localparam logic        DMAP_INCR_RST   = 1'b0;
  localparam logic [31:0] DMAP_ADDR_RST   = 32'h00000000;
  localparam logic [31:0] DMAP_DATA_RST   = 32'h00000000;

  // bus transfer types
  localparam logic [1:0]  DMAP_HTRANS_IDLE   = 2'h0;
  localparam logic [1:0]  DMAP_HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    DMAP_IDLE,
    DMAP_ADDR_PH,
    DMAP_DATA_PH
  } dmap_state_t;

  // low address bits that must be zero for a naturally aligned transfer
  function automatic logic [1:0] dmap_low_mask(input logic [2:0] size);
    logic [1:0] m;
    m = 2'h0;
    case (size)
      DMAP_SIZE_HALF: m = 2'h1;
      DMAP_SIZE_WORD: m = 2'h3;
      default:        m = 2'h0;
    endcase
    return m;
  endfunction

  // bytes moved by one transfer
  function automatic logic [31:0] dmap_step(input logic [2:0] size);
    logic [31:0] s;
    s = 32'h00000001;
    case (size)
      DMAP_SIZE_HALF: s = 32'h00000002;
      DMAP_SIZE_WORD: s = 32'h00000004;
      default:        s = 32'h00000001;
    endcase
    return s;
  endfunction

  function automatic logic dmap_size_ok(input logic [2:0] size);
    return (size <= DMAP_SIZE_WORD);
  endfunction

endpackage
`default_nettype wire

// ===== rtl/dmap_port.sv
`timescale 1ns/10ps
`default_nettype none
module dmap_port (
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  input  wire logic                          dbg_req,
  input  wire logic                          dbg_wr,
  input  wire logic [dmap_pkg::DMAP_SEL_W-1:0] dbg_sel,
  input  wire logic [31:0]                   dbg_wdata,
  output logic                               dbg_ready,
  output logic                               dbg_ack,
  output logic [31:0]                        dbg_rdata,
  input  wire logic                          align_fix_en,
  output logic [31:0]                        haddr,
  output logic [1:0]                         htrans,
  output logic                               hwrite,
  output logic [2:0]                         hsize,
  output logic [31:0]                        hwdata,
  input  wire logic [31:0]                   hrdata,
  input  wire logic                          hready,
  input  wire logic                          hresp
);
  import dmap_pkg::*;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  dmap_state_t state_r;
  dmap_state_t state_nxt;
  logic [31:0] addr_r;
  logic [2:0]  size_r;
  logic        incr_r;
  logic        err_r;
  logic [31:0] haddr_r;
  logic [1:0]  htrans_r;
  logic        hwrite_r;
  logic [2:0]  hsize_r;
  logic [31:0] hwdata_r;
  logic [31:0] rdata_r;
  logic        ack_r;
  logic        take;
  logic        data_go;
  logic        bad_size;
  logic        bus_done;
  logic        ctrl_wr;
  logic [31:0] ctrl_view;

  dmap_align_if u_align_if ();

  dmap_addr_align u_align (
    .p (u_align_if.calc)
  );

  assign u_align_if.addr   = addr_r;
  assign u_align_if.size   = size_r;
  assign u_align_if.fix_en = align_fix_en;

  // debugger handshake
  assign dbg_ready = (state_r == DMAP_IDLE);
  assign take      = dbg_req && dbg_ready;
  assign bad_size  = !dmap_size_ok(size_r);
  assign data_go   = take && (dbg_sel == DMAP_SEL_DATA)
                     && !bad_size;
  assign bus_done  = (state_r == DMAP_DATA_PH) && hready;
  assign ctrl_wr   = take && dbg_wr && (dbg_sel == DMAP_SEL_CTRL);

  assign ctrl_view = {24'h000000, (state_r != DMAP_IDLE), err_r, 1'b0,
                      incr_r, 1'b0, size_r};

  // transfer sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DMAP_IDLE: begin
        if (data_go) begin
          state_nxt = DMAP_ADDR_PH;
        end
      end
      DMAP_ADDR_PH: begin
        if (hready) begin
          state_nxt = DMAP_DATA_PH;
        end
      end
      DMAP_DATA_PH: begin
        if (hready) begin
          state_nxt = DMAP_IDLE;
        end
      end
      default: state_nxt = DMAP_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= DMAP_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // transfer address register with optional auto-increment
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= DMAP_ADDR_RST;
    end else if (take && dbg_wr && (dbg_sel == DMAP_SEL_ADDR)) begin
      addr_r <= dbg_wdata;
    end else if (bus_done && !hresp && incr_r) begin
      addr_r <= 32'(addr_r + dmap_step(size_r));
    end
  end

  a_addr_hold: assert property (
    (take && dbg_wr && dbg_sel == DMAP_SEL_ADDR) |=>
      (addr_r == $past(dbg_wdata)))
    else $error("address register did not take debugger write");

  // access control register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      size_r <= DMAP_SIZE_RST;
      incr_r <= DMAP_INCR_RST;
    end else if (ctrl_wr) begin
      size_r <= dbg_wdata[DMAP_SIZE_LSB +: DMAP_SIZE_W];
      incr_r <= dbg_wdata[DMAP_INCR_BIT];
    end
  end

  // sticky error, set wins over write-one-to-clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_r <= 1'b0;
    end else if ((bus_done && hresp) ||
                 (take && dbg_sel == DMAP_SEL_DATA && bad_size)) begin
      err_r <= 1'b1;
    end else if (ctrl_wr && dbg_wdata[DMAP_ERR_BIT]) begin
      err_r <= 1'b0;
    end
  end

  a_err_sticky: assert property (
    (bus_done && hresp) |=> err_r)
    else $error("bus error not recorded");

  // address phase outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      haddr_r  <= DMAP_ADDR_RST;
      hsize_r  <= DMAP_SIZE_RST;
      hwrite_r <= 1'b0;
    end else if (data_go) begin
      haddr_r  <= u_align_if.bus_addr;
      hsize_r  <= size_r;
      hwrite_r <= dbg_wr;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      htrans_r <= DMAP_HTRANS_IDLE;
    end else if (data_go) begin
      htrans_r <= DMAP_HTRANS_NONSEQ;
    end else if ((state_r == DMAP_ADDR_PH) && hready) begin
      htrans_r <= DMAP_HTRANS_IDLE;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hwdata_r <= DMAP_DATA_RST;
    end else if (data_go && dbg_wr) begin
      hwdata_r <= dbg_wdata;
    end
  end

  a_low_bits: assert property (
    (data_go && !align_fix_en) |=>
      (haddr[1:0] == $past(addr_r[1:0])))
    else $error("low address bits not driven from address register");

  a_start_xfer: assert property (
    data_go |=> (htrans == DMAP_HTRANS_NONSEQ) &&
      (hwrite == $past(dbg_wr)))
    else $error("data register access did not start a transfer");

  a_size_drive: assert property (
    data_go |=> (hsize == $past(size_r)))
    else $error("hsize differs from access control size");

  a_pass_unaligned: assert property (
    (data_go && !align_fix_en) |=> (haddr == $past(addr_r)))
    else $error("address altered while alignment forcing is off");

  a_force_align: assert property (
    (data_go && align_fix_en) |=>
      ((haddr[1:0] & dmap_low_mask(hsize)) == 2'h0) &&
      (haddr[31:2] == $past(addr_r[31:2])))
    else $error("forced alignment left low address bits set");

  // debugger answer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (take && !data_go) || bus_done;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= DMAP_DATA_RST;
    end else if (take && !dbg_wr && dbg_sel == DMAP_SEL_CTRL) begin
      rdata_r <= ctrl_view;
    end else if (take && !dbg_wr && dbg_sel == DMAP_SEL_ADDR) begin
      rdata_r <= addr_r;
    end else if (take && !dbg_wr && !data_go) begin
      rdata_r <= DMAP_DATA_RST;
    end else if (bus_done && !hwrite_r) begin
      rdata_r <= hresp ? DMAP_DATA_RST : hrdata;
    end
  end

  sequence s_issue;
    data_go ##1 (state_r == DMAP_ADDR_PH) && (htrans == DMAP_HTRANS_NONSEQ);
  endsequence

  sequence s_finish;
    (state_r == DMAP_ADDR_PH) && hready ##1
      (state_r == DMAP_DATA_PH) && hready;
  endsequence

  a_xfer_done: assert property (
    s_issue ##0 s_finish |=> dbg_ack && (htrans == DMAP_HTRANS_IDLE))
    else $error("completed transfer not acknowledged");

  assign dbg_ack   = ack_r;
  assign dbg_rdata = rdata_r;
  assign haddr     = haddr_r;
  assign htrans    = htrans_r;
  assign hwrite    = hwrite_r;
  assign hsize     = hsize_r;
  assign hwdata    = hwdata_r;

endmodule
`default_nettype wire

// ===== tb/dmap_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
module dmap_bus_model (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hready,
  output logic             hresp,
  output logic [31:0]      wr_data_r,
  output logic [31:0]      txn_cnt_r
);
  logic        dp_r;
  logic        wr_r;
  logic [31:0] a_r;
  logic [1:0]  wait_r;
  logic        rd_on;
  // slave answers from its address; off the read beat it drives the inverse
  assign hready = !(dp_r && wait_r != 2'h0);
  assign hresp  = dp_r && hready && a_r[31:28] == 4'hE;
  assign rd_on  = dp_r && hready && !wr_r;
  assign hrdata = {a_r[15:0], ~a_r[15:0]} ^ {32{!rd_on}};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_r      <= 1'b0;
      wr_r      <= 1'b0;
      a_r       <= 32'h00000000;
      wait_r    <= 2'h0;
      wr_data_r <= 32'h00000000;
      txn_cnt_r <= 32'h00000000;
    end else if (hready && htrans == 2'h2) begin
      dp_r      <= 1'b1;
      wr_r      <= hwrite;
      a_r       <= haddr;
      wait_r    <= slow ? 2'h2 : 2'h0;
      txn_cnt_r <= txn_cnt_r + 32'h1;
    end else if (dp_r) begin
      if (hready) begin
        dp_r <= 1'b0;
        if (wr_r) begin
          wr_data_r <= hwdata;
        end
      end else begin
        wait_r <= wait_r - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import dmap_pkg::*;
  logic             core_clk, rst_n, dbg_req, dbg_wr, align_fix_en, slow;
  logic [1:0]       dbg_sel;
  logic [31:0]      dbg_wdata, rd, a;
  logic [2:0]       sz;
  wire logic        dbg_ready, dbg_ack, hwrite, hready, hresp;
  wire logic [31:0] dbg_rdata, haddr, hwdata, hrdata, wr_data_r, txn_cnt_r;
  wire logic [1:0]  htrans;
  wire logic [2:0]  hsize;
  int               num_errors, cmp_count, seed, i;
  dmap_port uut (.core_clk, .rst_n, .dbg_req, .dbg_wr, .dbg_sel, .dbg_wdata,
    .dbg_ready, .dbg_ack, .dbg_rdata, .align_fix_en, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hrdata, .hready, .hresp);
  dmap_bus_model bus (.core_clk, .rst_n, .slow, .haddr, .htrans, .hwrite,
    .hwdata, .hrdata, .hready, .hresp, .wr_data_r, .txn_cnt_r);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // one debugger access, entered and left at a falling edge
  task automatic acc(input logic w, input logic [1:0] s,
                     input logic [31:0] d, output logic [31:0] q);
    int j;
    dbg_req = 1'b1;
    dbg_wr = w;
    dbg_sel = s;
    dbg_wdata = d;
    j = 0;
    while (dbg_ready !== 1'b1 && j < 50) begin
      @(negedge core_clk);
      j++;
    end
    @(negedge core_clk);
    dbg_req = 1'b0;
    while (dbg_ack !== 1'b1 && j < 50) begin
      @(negedge core_clk);
      j++;
    end
    if (j >= 50) begin
      num_errors++;
      test_done();
    end else begin
      q = dbg_rdata;
    end
  endtask
  function automatic logic [31:0] ex_addr(input logic [31:0] t,
                                          input logic [2:0] s, input logic f);
    logic [1:0] m;
    m = (s == 3'h2) ? 2'h3 : (s == 3'h1) ? 2'h1 : 2'h0;
    return f ? {t[31:2], t[1:0] & ~m} : t;
  endfunction
  task automatic xfer(input logic w, input logic [31:0] t, input logic [2:0] s,
                      input logic f, input logic [31:0] d);
    logic [31:0] e;
    logic [31:0] n;
    e = ex_addr(t, s, f);
    align_fix_en = f;
    acc(1'b1, DMAP_SEL_CTRL, {29'h0, s}, rd);
    acc(1'b1, DMAP_SEL_ADDR, t, rd);
    n = txn_cnt_r;
    acc(w, DMAP_SEL_DATA, d, rd);
    check(txn_cnt_r, n + 32'h1);
    check(haddr, e);
    check({29'h0, hsize}, {29'h0, s});
    check({31'h0, hwrite}, {31'h0, w});
    check({30'h0, htrans}, {30'h0, DMAP_HTRANS_IDLE});
    check(w ? wr_data_r : rd, w ? d : {e[15:0], ~e[15:0]});
  endtask
  initial begin
    seed = 92082;
    num_errors = 0;
    cmp_count = 0;
    {rst_n, dbg_req, dbg_wr, align_fix_en, slow} = 5'h00;
    dbg_sel = 2'h0;
    dbg_wdata = 32'h00000000;
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    acc(1'b0, DMAP_SEL_CTRL, 32'h0, rd);
    check(rd, {29'h0, DMAP_SIZE_RST});
    acc(1'b1, DMAP_SEL_ADDR, 32'h12345673, rd);
    acc(1'b0, DMAP_SEL_ADDR, 32'h0, rd);
    check(rd, 32'h12345673);
    $display("test registers done");
    // every size, both modes, both directions, worst misalignment
    for (i = 0; i < 12; i++) begin
      xfer(i[0], 32'h20000003, 3'(i / 4), i[1], 32'hA5C30000 + i);
    end
    $display("test corners done");
    for (i = 0; i < 40; i++) begin
      sz = 3'($unsigned($random(seed)) % 3);
      a = $random(seed);
      a[31] = 1'b0;
      slow = 1'($random(seed));
      if (i[0]) begin
        a = ex_addr(a, sz, 1'b1);
      end
      xfer(1'($random(seed)), a, sz, 1'($random(seed)), $random(seed));
    end
    slow = 1'b0;
    $display("test random done");
    acc(1'b1, DMAP_SEL_CTRL, 32'h12, rd);
    acc(1'b1, DMAP_SEL_ADDR, 32'h100, rd);
    acc(1'b1, DMAP_SEL_DATA, 32'h5A, rd);
    acc(1'b0, DMAP_SEL_ADDR, 32'h0, rd);
    check(rd, 32'h104);
    acc(1'b1, DMAP_SEL_CTRL, 32'h2, rd);
    acc(1'b1, DMAP_SEL_ADDR, 32'hE0000000, rd);
    acc(1'b0, DMAP_SEL_DATA, 32'h0, rd);
    check(rd, 32'h0);
    acc(1'b0, DMAP_SEL_CTRL, 32'h0, rd);
    check(rd, 32'h42);
    acc(1'b1, DMAP_SEL_CTRL, 32'h43, rd);
    acc(1'b0, DMAP_SEL_CTRL, 32'h0, rd);
    check(rd, 32'h3);
    acc(1'b0, DMAP_SEL_DATA, 32'h0, rd);
    check(txn_cnt_r, 32'h36);
    check(rd, 32'h0);
    acc(1'b0, DMAP_SEL_CTRL, 32'h0, rd);
    check(rd, 32'h43);
    $display("test increment and errors done");
    test_done();
  end
endmodule
`default_nettype wire
